/* sim/testbench.sv */
// Self-checking bench for the transmit gain control
`include "txg_params.svh"
`default_nettype none
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin n_errors++; $display("ERROR %0t mismatch %h %h", $time, a, b); end end
module testbench;
	timeunit 1ns;
	timeprecision 100ps;
	import txg_pkg::*;
	localparam logic [11:0] TXROW [7] = '{12'h000, 12'h041, 12'h2CB, 12'h310, 12'h661,
		12'h9F3, 12'hFF3};
	localparam logic [23:0] IPROW [4] = '{24'h40222B, 24'hC0222B, 24'h800100, 24'h003430};
	logic        sys_clk = 1'b0;
	logic        reset = 1'b1;
	logic [5:0]  gwp = 6'h00;
	logic [5:0]  txp = 6'h00;
	logic        dpx = 1'b0;
	logic        stb = 1'b0;
	logic        tx_valid = 1'b0;
	logic [11:0] tx_data = 12'h000;
	logic        sclk, sen_n, sdi, spi_sdo, tx_ready, dac_valid, amp_route, conv_out_en;
	logic        hb1_en, hb2_en, tx_power_down;
	logic [11:0] dac_data;
	logic [5:0]  rx_gain_code, latency_half;
	logic [7:0]  rx_gain_db, q;
	logic [2:0]  primary_gain, interp_factor;
	txg_atten_t  tx_atten;
	txg_pins_t   pins;
	int          n_errors = 0;
	int          num_checks = 0;
	int          cyc = 0;
	int          k;
	logic [11:0] got [$];
	// Duplex, strobe and transmit port driven by the bench; compatibility strap set
	assign pins = {dpx, 1'b1, stb, txp, gwp, sclk, sen_n, sdi};
	txg_top DUT (.sys_clk(sys_clk), .reset(reset), .pins(pins), .spi_sdo(spi_sdo),
		.tx_valid(tx_valid), .tx_ready(tx_ready), .tx_data(tx_data), .dac_data(dac_data),
		.dac_valid(dac_valid), .rx_gain_code(rx_gain_code), .rx_gain_db(rx_gain_db),
		.tx_atten(tx_atten), .amp_route(amp_route), .conv_out_en(conv_out_en),
		.primary_gain(primary_gain), .interp_factor(interp_factor), .hb1_en(hb1_en),
		.hb2_en(hb2_en), .latency_half(latency_half), .tx_power_down(tx_power_down));
	txg_host HOST (.sys_clk(sys_clk), .sdo(spi_sdo), .sclk(sclk), .sen_n(sen_n), .sdi(sdi));
	always #20 sys_clk = ~sys_clk;
	always @(posedge sys_clk) begin
		if (dac_valid === 1'b1)
			got.push_back(dac_data);
	end
	always @(posedge sys_clk) begin
		cyc++;
		if (cyc == 20000) begin
			n_errors++;
			$display("ERROR %0t timeout", $time);
			complete_run();
		end
	end
	task automatic tick(input int n);
		repeat (n) @(posedge sys_clk);
		#1;
	endtask : tick
	task automatic complete_run();
		$display("checks %0d errors %0d", num_checks, n_errors);
		if (n_errors == 0 && num_checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : complete_run
	initial begin
		logic [7:0] e;
		tick(10);
		reset = 1'b0;
		tick(4);
		`CHK(tx_atten, 7'h40)
		`CHK(primary_gain, 3'h4)
		`CHK(interp_factor, 3'h4)
		`CHK(conv_out_en, 1'b1)
		`CHK(amp_route, 1'b1)
		`CHK(rx_gain_db, 8'hF4)
		// Port must not reach tx gain yet, but feeds rx by default
		gwp = 6'h15;
		tick(6);
		`CHK(tx_atten, 7'h40)
		`CHK(rx_gain_code, 6'h15)
		`CHK(rx_gain_db, 8'hFC)
		$display("test reset done");
		for (int c = 0; c < 8; c++) begin
			gwp = 6'(c * 8);
			e = (c == 0) ? 8'hF4 : 8'(8 * c - 20);
			tick(6);
			`CHK(rx_gain_db, e)
		end
		HOST.wr(`TXG_A_GSEL, 8'h20);
		gwp = 6'h20;
		tick(6);
		`CHK(rx_gain_db, 8'h14)
		// Deselect rx, present the value, then select tx
		HOST.wr(`TXG_A_GSEL, 8'h00);
		gwp = 6'h09;
		tick(6);
		HOST.wr(`TXG_A_GSEL, 8'h40);
		tick(6);
		`CHK(tx_atten.dac_steps, 4'h9)
		`CHK(rx_gain_code, 6'h20)
		gwp = 6'h0E;
		tick(6);
		// Code 14 splits into one amplifier step and two converter steps
		`CHK(tx_atten, 7'h52)
		HOST.wr(`TXG_A_GSEL, 8'h00);
		$display("test gain port done");
		for (int i = 0; i < 7; i++) begin
			HOST.wr(`TXG_A_TXGAIN, {2'b01, TXROW[i][11:6]});
			tick(4);
			`CHK(tx_atten, {1'b1, TXROW[i][5:0]})
			HOST.rd(`TXG_A_TXGAIN, q);
			`CHK(q, {2'b00, TXROW[i][11:6]})
		end
		HOST.wr(`TXG_A_TXGAIN, 8'h05);
		tick(4);
		`CHK(tx_atten, 7'h73)
		HOST.wr(`TXG_A_OUTSEL, 8'h01);
		tick(4);
		`CHK(tx_atten, 7'h4F)
		`CHK(amp_route, 1'b0)
		`CHK(conv_out_en, 1'b1)
		HOST.wr(`TXG_A_OUTSEL, 8'h00);
		$display("test tx gain done");
		HOST.wr(`TXG_A_MIR1, 8'h03);
		tick(4);
		`CHK(primary_gain, 3'h4)
		HOST.wr(`TXG_A_MIR1, 8'h83);
		tick(4);
		`CHK(primary_gain, 3'h3)
		`CHK(tx_atten.valid, 1'b0)
		for (int i = 0; i < 4; i++) begin
			HOST.wr(`TXG_A_INTERP, IPROW[i][23:16]);
			tick(4);
			`CHK({hb1_en, hb2_en}, IPROW[i][13:12])
			`CHK(interp_factor, IPROW[i][10:8])
			`CHK(latency_half, IPROW[i][5:0])
		end
		$display("test config done");
		// Push one word a cycle against a 4x drain until the FIFO refuses
		k = 0;
		got.delete();
		tx_valid = 1'b1;
		for (int i = 0; i < 100 && tx_ready === 1'b1; i++) begin
			tick(1);
			k++;
			tx_data = 12'(k);
		end
		`CHK(tx_ready, 1'b0)
		`CHK(k >= 32, 1'b1)
		tx_valid = 1'b0;
		for (int i = 0; i < 400 && got.size() < k; i++)
			tick(1);
		tick(20);
		`CHK(got.size(), k)
		for (int i = 0; i < got.size(); i++)
			`CHK(got[i], 12'(i))
		$display("test fifo done");
		HOST.wr(`TXG_A_PDLY, 8'h85);
		for (int i = 0; i < 40 && tx_power_down !== 1'b1; i++)
			tick(1);
		`CHK(tx_power_down, 1'b1)
		tx_valid = 1'b1;
		tick(1);
		tx_valid = 1'b0;
		tick(2);
		`CHK(tx_power_down, 1'b0)
		tick(2);
		`CHK(tx_power_down, 1'b0)
		$display("test power down done");
		// Second reset in full duplex: rx gain defaults to the transmit port route
		dpx = 1'b1;
		reset = 1'b1;
		tick(10);
		reset = 1'b0;
		tick(4);
		`CHK(tx_atten, 7'h40)
		`CHK(rx_gain_code, 6'h00)
		txp = 6'h1A;
		tick(6);
		`CHK(rx_gain_code, 6'h00)
		stb = 1'b1;
		tick(6);
		`CHK(rx_gain_code, 6'h1A)
		`CHK(rx_gain_db, 8'h0E)
		stb = 1'b0;
		HOST.wr(`TXG_A_GSEL, 8'h0C);
		txp = 6'h05;
		tick(6);
		`CHK(rx_gain_code, 6'h05)
		HOST.wr(`TXG_A_INTERP, 8'h80);
		tick(4);
		`CHK(interp_factor, 3'h4)
		$display("test full duplex done");
		complete_run();
	end
endmodule : testbench
`default_nettype wire

/* sim/txg_host.sv */
// SPI host model that programs the transmit gain control
`default_nettype none
module txg_host (
	input  wire logic sys_clk,
	input  wire logic sdo,
	output var logic  sclk,
	output var logic  sen_n,
	output var logic  sdi
);
	timeunit 1ns;
	timeprecision 100ps;
	initial begin
		sclk = 1'b0;
		sen_n = 1'b1;
		sdi = 1'b0;
	end
	task automatic wt(input int n);
		repeat (n) @(posedge sys_clk);
		#1;
	endtask : wt
	// Four clocks per sclk phase; the sampler needs three
	task automatic frame(input logic [15:0] f, output logic [7:0] q);
		sen_n = 1'b0;
		for (int i = 15; i >= 0; i--) begin
			sdi = f[i];
			wt(4);
			if (i < 8)
				q[i] = sdo;
			sclk = 1'b1;
			wt(4);
			sclk = 1'b0;
		end
		wt(4);
		sen_n = 1'b1;
		// Released line shows the inverse, never the stale bit
		sdi = ~sdi;
		wt(4);
	endtask : frame
	task automatic wr(input logic [6:0] a, input logic [7:0] d);
		logic [7:0] x;
		frame({1'b0, a, d}, x);
	endtask : wr
	task automatic rd(input logic [6:0] a, output logic [7:0] d);
		frame({1'b1, a, 8'h40}, d);
	endtask : rd
endmodule : txg_host
`default_nettype wire

/* src/txg_params.svh */
// Register offsets, field positions, reset values and counts for the transmit gain control
`ifndef TXG_PARAMS_SVH
`define TXG_PARAMS_SVH

`define TXG_A_TXGAIN  7'h0A
`define TXG_A_GSEL    7'h0B
`define TXG_A_INTERP  7'h0C
`define TXG_A_OUTSEL  7'h0E
`define TXG_A_PDLY    7'h0F
`define TXG_A_MIR1    7'h10
`define TXG_A_MIR2    7'h11

`define TXG_TXG_EN    6
`define TXG_GS_TX     6
`define TXG_GS_RX     5
`define TXG_GS_SWSTB  3
`define TXG_GS_RXTX   2
`define TXG_GS_MAP3   1
`define TXG_OS_DAC    0
`define TXG_MIR_EN    7
`define TXG_PD_EN     7

`define TXG_MIR1_RST  8'h44
`define TXG_MIR2_RST  8'h00
`define TXG_PDLY_RST  8'h30
`define TXG_PGAIN_MAX 3'h4
`define TXG_PINS_RST  18'h00002

`define TXG_IF_X4     2'h0
`define TXG_IF_X2     2'h1
`define TXG_IF_X1     2'h2
`define TXG_IF_BAD    2'h3

`define TXG_HALF_MAX  6'h27
`define TXG_AMP_STEP  6'h0C
`define TXG_RX_OFS    8'h0C
`define TXG_MAP3_OFS  8'h14
`define TXG_RX_DB_MIN 8'hF4

`define TXG_HB1_TAPS  43
`define TXG_HB2_TAPS  11
`define TXG_LAT2_HALF 6'h2B
`define TXG_LAT4_HALF 6'h30

`define TXG_SPI_CMD   5'h07
`define TXG_SPI_LAST  5'h0F

`endif

/* src/txg_pkg.sv */
// Types shared by the transmit gain control
`default_nettype none
package txg_pkg;
	typedef struct packed {
		logic       duplex;
		logic       compat;
		logic       strobe;
		logic [5:0] tx_port;
		logic [5:0] gain_word_port;
		logic       sclk;
		logic       sen_n;
		logic       sdi;
	} txg_pins_t;

	typedef struct packed {
		logic       valid;
		logic [1:0] amp_steps;
		logic [3:0] dac_steps;
	} txg_atten_t;

	typedef enum logic [1:0] {
		PD_RUN  = 2'b00,
		PD_WAIT = 2'b01,
		PD_OFF  = 2'b10
	} txg_pd_t;
endpackage : txg_pkg
`default_nettype wire

/* src/txg_top.sv */
// Transmit gain, receive gain mapping, interpolation control and sample FIFO
// Function
// - 3-bit rx map: -12 dB, then +8 dB
// - Full duplex: rx gain via tx port
// - Half duplex: rx gain via gain port
// - Software strobe updates rx gain continuously
// - Six-bit tx code, 0.5 dB steps
// - Converter-only map uses four low bits
// - Tx gain SPI writes need bit 6
// - Reset: minimum attenuation, port off tx gain; feeds rx in half duplex
// - Select bits route gain port to registers
// - Interpolation factor select; code 11 forbidden
// - Two half-band stages, 43 and 11 taps
// - Latency 21.5 or 24 input cycles
// - Delayed power-down after last sample, half duplex only
// - Converter pins always live; bit routes amplifier
// - Primary mirror gain 0 to 4, default 4
// - Primary mirror gain writes need bit 7
// - Amplifier span valid only at mirror defaults
// - Gain port passes without strobe
`include "txg_params.svh"
`default_nettype none

module txg_fifo #(
	parameter int W = 12,
	parameter int D = 32
) (
	input  wire logic         sys_clk,
	input  wire logic         reset,
	input  wire logic         in_valid,
	output logic              in_ready,
	input  wire logic [W-1:0] in_data,
	output logic              out_valid,
	input  wire logic         out_ready,
	output logic      [W-1:0] out_data
);
	localparam int AW = $clog2(D);
	logic [W-1:0] mem [D];
	logic [AW-1:0] wp_r;
	logic [AW-1:0] rp_r;
	logic [AW:0]   cnt_r;
	wire           push = in_valid & in_ready;
	wire           pop  = out_valid & out_ready;
	wire [AW:0]    cnt_nxt = cnt_r + (AW+1)'(push) - (AW+1)'(pop);
	assign out_data = mem[rp_r];

	always_ff @(posedge sys_clk) begin
		if (push) begin
			mem[wp_r] <= in_data;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (reset) begin
			wp_r      <= '0;
			rp_r      <= '0;
			cnt_r     <= '0;
			in_ready  <= 1'b0;
			out_valid <= 1'b0;
		end else begin
			wp_r      <= push ? AW'(wp_r + 1'b1) : wp_r;
			rp_r      <= pop ? AW'(rp_r + 1'b1) : rp_r;
			cnt_r     <= cnt_nxt;
			in_ready  <= cnt_nxt != (AW+1)'(D);
			out_valid <= cnt_nxt != '0;
		end
	end
endmodule : txg_fifo

module txg_top #(
	parameter int DW    = 12,
	parameter int DEPTH = 32
) (
	input  wire logic               sys_clk,
	input  wire logic               reset,
	input  wire txg_pkg::txg_pins_t pins,
	output logic                    spi_sdo,
	input  wire logic               tx_valid,
	output logic                    tx_ready,
	input  wire logic [DW-1:0]      tx_data,
	output logic      [DW-1:0]      dac_data,
	output logic                    dac_valid,
	output logic      [5:0]         rx_gain_code,
	output logic      [7:0]         rx_gain_db,
	output txg_pkg::txg_atten_t     tx_atten,
	output logic                    amp_route,
	output logic                    conv_out_en,
	output logic      [2:0]         primary_gain,
	output logic      [2:0]         interp_factor,
	output logic                    hb1_en,
	output logic                    hb2_en,
	output logic      [5:0]         latency_half,
	output logic                    tx_power_down
);
	import txg_pkg::*;

	txg_pins_t  pm_r;
	txg_pins_t  ps_r;
	logic       sclk_d_r;
	logic [4:0] bit_cnt_r;
	logic [15:0] sh_r;
	logic [7:0] rd_sh_r;
	logic       wr_stb_r;
	logic [6:0] wr_addr_r;
	logic [7:0] wr_data_r;
	logic       init_r;
	logic [5:0] tx_gain_r;
	logic [7:0] gsel_r;
	logic [7:0] ic_r;
	logic [7:0] outsel_r;
	logic [7:0] pdly_r;
	logic [7:0] mir1_r;
	logic [7:0] mir2_r;
	logic [5:0] rx_gain_r;
	logic [1:0] phase_r;
	logic [7:0] pd_cnt_r;
	txg_pd_t    pd_r;
	txg_pd_t    pd_nxt;
	logic       fifo_valid;
	logic [DW-1:0] fifo_data;

	// Edge detect reads only the second synchroniser stage
	wire sclk_rise = ps_r.sclk & ~sclk_d_r;
	wire sclk_fall = ~ps_r.sclk & sclk_d_r;
	wire [6:0] cmd_addr = {sh_r[5:0], ps_r.sdi};
	wire       cmd_read = sh_r[6];

	wire wr_tx   = wr_stb_r & (wr_addr_r == `TXG_A_TXGAIN) & wr_data_r[`TXG_TXG_EN];
	wire wr_gsel = wr_stb_r & (wr_addr_r == `TXG_A_GSEL);
	wire wr_ic   = wr_stb_r & (wr_addr_r == `TXG_A_INTERP);
	wire wr_os   = wr_stb_r & (wr_addr_r == `TXG_A_OUTSEL);
	wire wr_pd   = wr_stb_r & (wr_addr_r == `TXG_A_PDLY);
	wire wr_m1   = wr_stb_r & (wr_addr_r == `TXG_A_MIR1) & wr_data_r[`TXG_MIR_EN];
	wire wr_m2   = wr_stb_r & (wr_addr_r == `TXG_A_MIR2);

	wire [7:0] rd_val =
		(cmd_addr == `TXG_A_TXGAIN) ? {2'h0, tx_gain_r} :
		(cmd_addr == `TXG_A_GSEL)   ? gsel_r :
		(cmd_addr == `TXG_A_INTERP) ? ic_r :
		(cmd_addr == `TXG_A_OUTSEL) ? outsel_r :
		(cmd_addr == `TXG_A_PDLY)   ? pdly_r :
		(cmd_addr == `TXG_A_MIR1)   ? mir1_r :
		(cmd_addr == `TXG_A_MIR2)   ? mir2_r : 8'h00;

	// Forbidden codes, and bypass in full duplex, leave the factor unchanged
	wire [1:0] ic_new  = wr_data_r[7:6];
	wire       ic_ok   = (ic_new != `TXG_IF_BAD) & ~(ic_new == `TXG_IF_X1 & ps_r.duplex);
	wire [1:0] ic_sel  = ic_ok ? ic_new : ic_r[7:6];

	wire sel_tx  = gsel_r[`TXG_GS_TX];
	wire sel_rx  = gsel_r[`TXG_GS_RX];
	wire map3    = gsel_r[`TXG_GS_MAP3];
	wire rx_strb = ps_r.strobe | gsel_r[`TXG_GS_SWSTB];
	wire rx_tx_upd = gsel_r[`TXG_GS_RXTX] & ps_r.duplex & rx_strb;

	// Composite span clamps at 19.5 dB; amplifier takes 6 dB chunks
	wire [5:0] half   = (tx_gain_r > `TXG_HALF_MAX) ? `TXG_HALF_MAX : tx_gain_r;
	wire [1:0] amp_n  = (half >= 6'(3 * `TXG_AMP_STEP)) ? 2'h3 :
	                    (half >= 6'(2 * `TXG_AMP_STEP)) ? 2'h2 :
	                    (half >= `TXG_AMP_STEP) ? 2'h1 : 2'h0;
	wire [5:0] amp_h  = 6'(amp_n * `TXG_AMP_STEP);
	wire [5:0] dac_h  = half - amp_h;
	wire       dac_only = outsel_r[`TXG_OS_DAC];
	wire       mir_dflt = (mir1_r == `TXG_MIR1_RST) & (mir2_r == `TXG_MIR2_RST);

	wire [2:0] c3      = rx_gain_r[5:3];
	wire [7:0] db3     = (c3 <= 3'h1) ? `TXG_RX_DB_MIN : {2'h0, c3, 3'h0} - `TXG_MAP3_OFS;
	wire [7:0] db6     = {2'h0, rx_gain_r} - `TXG_RX_OFS;

	wire [1:0] fact_m1 = (ic_r[7:6] == `TXG_IF_X4) ? 2'h3 :
	                     (ic_r[7:6] == `TXG_IF_X2) ? 2'h1 : 2'h0;
	// The drain is paced by the factor, so the FIFO really fills at 2x and 4x
	wire       take    = fifo_valid & (phase_r == 2'h0);
	wire       pd_act  = pdly_r[`TXG_PD_EN] & ~ps_r.duplex;
	wire       idle    = ~fifo_valid & ~tx_valid;

	txg_fifo #(.W(DW), .D(DEPTH)) u_fifo (
		.sys_clk   (sys_clk),
		.reset     (reset),
		.in_valid  (tx_valid),
		.in_ready  (tx_ready),
		.in_data   (tx_data),
		.out_valid (fifo_valid),
		.out_ready (take),
		.out_data  (fifo_data)
	);

	// Synchronisers run through reset so the mode straps are settled at release
	always_ff @(posedge sys_clk) begin
		pm_r     <= pins;
		ps_r     <= pm_r;
		sclk_d_r <= ps_r.sclk;
	end

	always_ff @(posedge sys_clk) begin
		if (reset || ps_r.sen_n) begin
			bit_cnt_r <= '0;
			sh_r      <= '0;
			rd_sh_r   <= '0;
			spi_sdo   <= 1'b0;
		end else if (sclk_rise) begin
			sh_r      <= {sh_r[14:0], ps_r.sdi};
			bit_cnt_r <= bit_cnt_r + 5'h01;
			if (bit_cnt_r == `TXG_SPI_CMD && cmd_read) begin
				rd_sh_r <= rd_val;
			end
		end else if (sclk_fall && bit_cnt_r > `TXG_SPI_CMD) begin
			spi_sdo <= rd_sh_r[7];
			rd_sh_r <= {rd_sh_r[6:0], 1'b0};
		end
	end

	always_ff @(posedge sys_clk) begin
		if (reset) begin
			wr_stb_r  <= 1'b0;
			wr_addr_r <= '0;
			wr_data_r <= '0;
		end else begin
			wr_stb_r  <= ~ps_r.sen_n & sclk_rise & (bit_cnt_r == `TXG_SPI_LAST) & ~sh_r[14];
			wr_addr_r <= sh_r[13:7];
			wr_data_r <= {sh_r[6:0], ps_r.sdi};
		end
	end

	// Mode-dependent defaults are taken from the pins one cycle after release
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			init_r <= 1'b1;
			gsel_r <= 8'h00;
		end else begin
			init_r <= 1'b0;
			if (init_r) begin
				gsel_r[`TXG_GS_RXTX] <= ps_r.duplex;
				gsel_r[`TXG_GS_RX]   <= ~ps_r.duplex;
				gsel_r[`TXG_GS_MAP3] <= ~ps_r.duplex & ps_r.compat;
			end else if (wr_gsel) begin
				gsel_r <= wr_data_r;
			end
		end
	end

	always_ff @(posedge sys_clk) begin
		if (reset) begin
			tx_gain_r <= 6'h00;
			rx_gain_r <= 6'h00;
			ic_r      <= 8'h00;
			outsel_r  <= 8'h00;
			pdly_r    <= `TXG_PDLY_RST;
			mir1_r    <= `TXG_MIR1_RST;
			mir2_r    <= `TXG_MIR2_RST;
		end else begin
			if (wr_tx) begin
				tx_gain_r <= wr_data_r[5:0];
			end else if (sel_tx) begin
				tx_gain_r <= ps_r.gain_word_port;
			end
			if (sel_rx) begin
				rx_gain_r <= ps_r.gain_word_port;
			end else if (rx_tx_upd) begin
				rx_gain_r <= ps_r.tx_port;
			end
			if (wr_ic) begin
				ic_r <= {ic_sel, wr_data_r[5:0]};
			end
			if (wr_os) begin
				outsel_r <= wr_data_r;
			end
			if (wr_pd) begin
				pdly_r <= wr_data_r;
			end
			if (wr_m1) begin
				mir1_r <= wr_data_r;
			end
			if (wr_m2) begin
				mir2_r <= wr_data_r;
			end
		end
	end

	always_comb begin
		pd_nxt = pd_r;
		unique case (pd_r)
			PD_RUN:  pd_nxt = (pd_act && idle) ? PD_WAIT : PD_RUN;
			PD_WAIT: pd_nxt = (!pd_act || !idle) ? PD_RUN :
			                  (pd_cnt_r >= {1'b0, pdly_r[6:0]}) ? PD_OFF : PD_WAIT;
			PD_OFF:  pd_nxt = (!pd_act || !idle) ? PD_RUN : PD_OFF;
			default: pd_nxt = PD_RUN;
		endcase
	end

	always_ff @(posedge sys_clk) begin
		if (reset) begin
			pd_r          <= PD_RUN;
			pd_cnt_r      <= '0;
			tx_power_down <= 1'b0;
			phase_r       <= '0;
			dac_data      <= '0;
			dac_valid     <= 1'b0;
		end else begin
			pd_r          <= pd_nxt;
			pd_cnt_r      <= (pd_r == PD_WAIT) ? pd_cnt_r + 8'h01 : 8'h00;
			tx_power_down <= pd_nxt == PD_OFF;
			phase_r       <= (phase_r >= fact_m1) ? 2'h0 : phase_r + 2'h1;
			dac_valid     <= take;
			dac_data      <= take ? fifo_data : dac_data;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (reset) begin
			rx_gain_code  <= '0;
			rx_gain_db    <= `TXG_RX_DB_MIN;
			tx_atten      <= '0;
			amp_route     <= 1'b0;
			conv_out_en   <= 1'b0;
			primary_gain  <= `TXG_PGAIN_MAX;
			interp_factor <= 3'h4;
			hb1_en        <= 1'b0;
			hb2_en        <= 1'b0;
			latency_half  <= '0;
		end else begin
			rx_gain_code  <= rx_gain_r;
			rx_gain_db    <= map3 ? db3 : db6;
			tx_atten.valid     <= dac_only | mir_dflt;
			tx_atten.amp_steps <= dac_only ? 2'h0 : amp_n;
			tx_atten.dac_steps <= dac_only ? tx_gain_r[3:0] : dac_h[3:0];
			conv_out_en   <= 1'b1;
			amp_route     <= ~dac_only;
			primary_gain  <= (mir1_r[2:0] > `TXG_PGAIN_MAX) ? `TXG_PGAIN_MAX : mir1_r[2:0];
			interp_factor <= {1'b0, fact_m1} + 3'h1;
			hb1_en        <= fact_m1 != 2'h0;
			hb2_en        <= fact_m1 == 2'h3;
			latency_half  <= (fact_m1 == 2'h3) ? `TXG_LAT4_HALF :
			                 (fact_m1 == 2'h1) ? `TXG_LAT2_HALF : 6'h00;
		end
	end

	default clocking @(posedge sys_clk); endclocking
	default disable iff (reset);

	chk_rx_map_min: assert property (map3 && c3 <= 3'h1 |=> rx_gain_db == `TXG_RX_DB_MIN)
		else $error("3-bit map low codes not -12 dB");
	chk_tx_spi_gate: assert property (wr_stb_r && wr_addr_r == `TXG_A_TXGAIN
		&& !wr_data_r[`TXG_TXG_EN] && !sel_tx |=> $stable(tx_gain_r))
		else $error("tx gain written without enable bit");
	chk_tx_reset_val: assert property ($fell(reset) |-> tx_gain_r == 6'h00 && !sel_tx)
		else $error("tx gain not minimum after reset");
	chk_port_pass: assert property (sel_tx && !wr_tx |=>
		tx_gain_r == $past(ps_r.gain_word_port))
		else $error("gain port did not reach tx gain");
	chk_interp_bad: assert property (wr_ic && wr_data_r[7:6] == `TXG_IF_BAD |=>
		$stable(ic_r[7:6]) ##1 $stable(interp_factor))
		else $error("forbidden factor accepted");
	chk_dac_only_map: assert property (dac_only |=> tx_atten.amp_steps == 2'h0
		&& tx_atten.dac_steps == $past(tx_gain_r[3:0]))
		else $error("converter-only mapping wrong");
	chk_mirror_gate: assert property (wr_stb_r && wr_addr_r == `TXG_A_MIR1
		&& !wr_data_r[`TXG_MIR_EN] |=> $stable(mir1_r))
		else $error("mirror gain written without enable bit");
	chk_pd_after_idle: assert property ($rose(tx_power_down) |-> $past(idle, 2)
		&& $past(pd_r == PD_WAIT))
		else $error("power-down without idle delay");
	chk_conv_pins_on: assert property (!$rose(reset) ##1 1'b1 |-> conv_out_en)
		else $error("converter pins dropped");
endmodule : txg_top
`default_nettype wire
